// *** hdl/cgs_status_flags.sv ***
// CAN general status and general interrupt flag registers
// Assumes a frame engine supplies levels and bit strobes, all on sys_clk
// Functional notes
// - Overload status bit 6 high while own overload frame is sent; no interrupt
// - Transmitter busy bit 4 high while any frame or ack is driven
// - Transmitter busy also high in interframe space if a frame waits
// - Receiver busy bit 3 high while a frame is acquired or monitored
// - Enable state bit 2 shows effective state, lagging the command
// - Status resets to zero; bits 7 and 5 undefined, never written with ones
// - Interrupt bit 7 is the image of all controller interrupts
// - Timer overrun bit 5 set when the timer wraps to zero
// - Timer overrun interrupts only when enabled; software clears it
// - Buffer overrun bit 4 set when the receive buffer fills
// - Stuff error bit 3 set on six equal consecutive bits
// - CRC error bit 2 set when computed and received CRC differ
// - Form error bit 1 set on a fixed-form field violation
// - Ack error bit 0 set when the ack slot stays recessive
// - Protocol engine starts three clocks after the enable command
// - Overload request sends after next message, clears as frame starts
`timescale 1ns/1ps
`include "cgs_params.svh"
module cgs_status_flags (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [7:0] sfrAddr,
   input wire logic sfrWr,
   input wire logic sfrRd,
   input wire logic [7:0] sfrWdata,
   output logic [7:0] sfrRdata,
   input wire cgs_pkg::cgs_frame_t frameIn,
   input wire cgs_pkg::cgs_bit_t bitIn,
   input wire logic [8:0] txErrCount,
   input wire logic [7:0] rxErrCount,
   input wire logic timerTick,
   input wire logic bufferFull,
   input wire logic controllerEnableCmd,
   input wire logic overloadRequestSet,
   input wire logic timerIrqEnable,
   input wire logic bufIrqEnable,
   input wire logic errIrqEnable,
   input wire logic otherIrq,
   output logic canIrq,
   output logic protoRun,
   output logic overloadRequest,
   output logic overloadGo
);
   import cgs_pkg::*;

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   cgs_status_t generalStatus_reg, generalStatus_next;
   cgs_irq_t generalIrqFlags_reg, generalIrqFlags_next;
   cgs_irq_t irqSet, irqKeep;
   cgs_ctl_state_t ctlState_reg, ctlState_next;
   logic [15:0] timer_reg, timer_next;
   logic [2:0] stuffCount_reg, stuffCount_next;
   logic lastBit_reg, lastBit_next;
   logic bufFull_reg;
   logic overloadRequest_next, overloadGo_next;
   logic canIrq_next, protoRun_next;
   logic [7:0] sfrRdata_next;
   logic crcMismatch, busOffLvl, errPassiveLvl;
   logic gitWrite;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   cgs_crc15 u_crc (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .clear(bitIn.strobe && bitIn.sof),
      .calcEn(bitIn.strobe && bitIn.crcCalc),
      .recvEn(bitIn.strobe && bitIn.crcRecv),
      .compare(bitIn.crcCompare),
      .bitValue(bitIn.value),
      .mismatch(crcMismatch)
   );

   cgs_fault_conf u_fault (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .txErrCount(txErrCount),
      .rxErrCount(rxErrCount),
      .busOff(busOffLvl),
      .errPassive(errPassiveLvl)
   );

   // ----------------------------------------
   // Enable sequencing
   // ----------------------------------------
   // Start takes three clocks; stop waits for traffic to end
   always_comb begin
      ctlState_next = ctlState_reg;
      case (ctlState_reg)
         CGS_OFF: begin
            if (controllerEnableCmd) begin
               ctlState_next = CGS_WAKE;
            end
         end
         CGS_WAKE: begin
            ctlState_next = controllerEnableCmd ? CGS_START : CGS_OFF;
         end
         CGS_START: begin
            ctlState_next = controllerEnableCmd ? CGS_RUN : CGS_OFF;
         end
         CGS_RUN: begin
            if (!controllerEnableCmd) begin
               ctlState_next = CGS_DRAIN;
            end
         end
         CGS_DRAIN: begin
            if (controllerEnableCmd) begin
               ctlState_next = CGS_RUN;
            end else if (!frameIn.txFrame && !frameIn.rxActive && !frameIn.ackDrive) begin
               ctlState_next = CGS_OFF;
            end
         end
         default: begin
            ctlState_next = CGS_OFF;
         end
      endcase
      protoRun_next = (ctlState_next == CGS_RUN) || (ctlState_next == CGS_DRAIN);
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ctlState_reg <= CGS_OFF;
         protoRun <= 1'b0;
      end else begin
         ctlState_reg <= ctlState_next;
         protoRun <= protoRun_next;
      end
   end

   // ----------------------------------------
   // General status image
   // ----------------------------------------
   // Live levels captured every clock, reserved bits read zero
   always_comb begin
      generalStatus_next = `CGS_GSTA_RST;
      generalStatus_next.overloadSendingFlag = frameIn.ovlSend;
      generalStatus_next.transmitterBusyFlag = frameIn.txFrame || frameIn.ackDrive
         || (frameIn.ifs && frameIn.frameWait);
      generalStatus_next.receiverBusyFlag = frameIn.rxActive;
      generalStatus_next.enableStateFlag = protoRun_next;
      generalStatus_next.busOffState = busOffLvl;
      generalStatus_next.errorPassiveState = errPassiveLvl;
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         generalStatus_reg <= `CGS_GSTA_RST;
      end else begin
         generalStatus_reg <= generalStatus_next;
      end
   end

   // ----------------------------------------
   // Event detection
   // ----------------------------------------
   // CAN timer and run-length of equal bus bits
   always_comb begin
      timer_next = timerTick ? timer_reg + 16'h0001 : timer_reg;
      stuffCount_next = stuffCount_reg;
      lastBit_next = lastBit_reg;
      if (bitIn.strobe) begin
         lastBit_next = bitIn.value;
         if (!bitIn.stuffRegion) begin
            stuffCount_next = `CGS_STUFF_ZERO;
         end else if (bitIn.value == lastBit_reg && stuffCount_reg != `CGS_STUFF_ZERO) begin
            stuffCount_next = (stuffCount_reg == `CGS_STUFF_LIMIT) ? `CGS_STUFF_ONE
               : stuffCount_reg + 3'h1;
         end else begin
            stuffCount_next = `CGS_STUFF_ONE;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         timer_reg <= `CGS_TIMER_ZERO;
         stuffCount_reg <= `CGS_STUFF_ZERO;
         lastBit_reg <= 1'b1;
         bufFull_reg <= 1'b0;
      end else begin
         timer_reg <= timer_next;
         stuffCount_reg <= stuffCount_next;
         lastBit_reg <= lastBit_next;
         bufFull_reg <= bufferFull;
      end
   end

   // ----------------------------------------
   // General interrupt flags
   // ----------------------------------------
   // Hardware set wins over a software write of zero
   always_comb begin
      gitWrite = sfrWr && (sfrAddr == `CGS_ADDR_GIT);
      irqSet = `CGS_GIT_RST;
      irqSet.timerOverrunFlag = timerTick && (timer_reg == `CGS_TIMER_MAX);
      irqSet.bufferOverrunFlag = bufferFull && !bufFull_reg;
      irqSet.stuffErrorFlag = bitIn.strobe && bitIn.stuffRegion
         && (bitIn.value == lastBit_reg) && (stuffCount_reg == `CGS_STUFF_LIMIT);
      irqSet.crcErrorFlag = crcMismatch;
      irqSet.formErrorFlag = bitIn.strobe && bitIn.fixedForm && !bitIn.value;
      irqSet.ackErrorFlag = bitIn.strobe && bitIn.ackSlot && bitIn.value;
      irqKeep = gitWrite ? cgs_irq_t'(sfrWdata) : cgs_irq_t'(~`CGS_GIT_RST);
      generalIrqFlags_next = (generalIrqFlags_reg & irqKeep) | irqSet;
      generalIrqFlags_next.resv6 = 1'b0;
      canIrq_next = (generalIrqFlags_next.timerOverrunFlag && timerIrqEnable)
         || (generalIrqFlags_next.bufferOverrunFlag && bufIrqEnable)
         || (errIrqEnable && (generalIrqFlags_next.stuffErrorFlag
            || generalIrqFlags_next.crcErrorFlag || generalIrqFlags_next.formErrorFlag
            || generalIrqFlags_next.ackErrorFlag))
         || otherIrq;
      generalIrqFlags_next.globalIrqImage = canIrq_next;
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         generalIrqFlags_reg <= `CGS_GIT_RST;
         canIrq <= 1'b0;
      end else begin
         generalIrqFlags_reg <= generalIrqFlags_next;
         canIrq <= canIrq_next;
      end
   end

   // ----------------------------------------
   // Overload request
   // ----------------------------------------
   // Armed by next received message, dropped when the frame begins
   always_comb begin
      overloadRequest_next = overloadRequest;
      overloadGo_next = overloadGo;
      if (frameIn.ovlStart) begin
         overloadRequest_next = 1'b0;
         overloadGo_next = 1'b0;
      end else if (overloadRequest && frameIn.rxMsgEnd) begin
         overloadGo_next = 1'b1;
      end
      if (overloadRequestSet) begin
         overloadRequest_next = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         overloadRequest <= 1'b0;
         overloadGo <= 1'b0;
      end else begin
         overloadRequest <= overloadRequest_next;
         overloadGo <= overloadGo_next;
      end
   end

   // ----------------------------------------
   // Register read port
   // ----------------------------------------
   // Read data registered one clock after the strobe
   always_comb begin
      sfrRdata_next = `CGS_RDATA_IDLE;
      if (sfrRd && sfrAddr == `CGS_ADDR_GSTA) begin
         sfrRdata_next = generalStatus_reg;
      end else if (sfrRd && sfrAddr == `CGS_ADDR_GIT) begin
         sfrRdata_next = generalIrqFlags_reg;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         sfrRdata <= `CGS_RDATA_IDLE;
      end else begin
         sfrRdata <= sfrRdata_next;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   a_ovl_status: assert property (frameIn.ovlSend |=> generalStatus_reg.overloadSendingFlag)
      else $error("Overload status missing");
   a_tx_busy: assert property (frameIn.txFrame || frameIn.ackDrive
      |=> generalStatus_reg.transmitterBusyFlag) else $error("Tx busy missing");
   a_ifs_busy: assert property (frameIn.ifs && frameIn.frameWait
      |=> generalStatus_reg.transmitterBusyFlag) else $error("Tx busy in IFS missing");
   a_rx_busy: assert property (frameIn.rxActive |=> generalStatus_reg.receiverBusyFlag)
      else $error("Rx busy missing");
   a_ena_lag: assert property ((ctlState_reg == CGS_OFF && controllerEnableCmd) ##1
      controllerEnableCmd ##1 controllerEnableCmd |-> ##1 generalStatus_reg.enableStateFlag
      && $past(!generalStatus_reg.enableStateFlag, 2)) else $error("Enable lag wrong");
   a_timer_wrap: assert property (timerTick && timer_reg == `CGS_TIMER_MAX
      |=> generalIrqFlags_reg.timerOverrunFlag && timer_reg == `CGS_TIMER_ZERO)
      else $error("Timer overrun missed");
   a_timer_irq: assert property (generalIrqFlags_reg.timerOverrunFlag && timerIrqEnable
      && !gitWrite |=> canIrq && generalIrqFlags_reg.globalIrqImage) else $error("Timer irq missing");
   a_stuff_err: assert property (irqSet.stuffErrorFlag |=> generalIrqFlags_reg.stuffErrorFlag)
      else $error("Stuff error missed");
   a_form_err: assert property (bitIn.strobe && bitIn.fixedForm && !bitIn.value
      |=> generalIrqFlags_reg.formErrorFlag) else $error("Form error missed");
   a_ack_err: assert property (bitIn.strobe && bitIn.ackSlot && bitIn.value
      |=> generalIrqFlags_reg.ackErrorFlag) else $error("Ack error missed");
   a_ovl_clear: assert property (frameIn.ovlStart && !overloadRequestSet
      |=> !overloadRequest && !overloadGo) else $error("Overload request not cleared");
   a_resv_zero: assert property (!generalStatus_reg.resv7 && !generalStatus_reg.resv5)
      else $error("Reserved status bits set");

   c_overload_go: cover property (overloadRequest && frameIn.rxMsgEnd ##1 overloadGo);
   c_crc_error: cover property (crcMismatch ##1 generalIrqFlags_reg.crcErrorFlag);
   c_enable_run: cover property (ctlState_reg == CGS_START ##1 ctlState_reg == CGS_RUN);

endmodule : cgs_status_flags

// *** hdl/cgs_params.svh ***
// Constants of the CAN general status and error flag block
// Assumes inclusion by bare name from the package and the modules
`ifndef CGS_PARAMS_SVH
`define CGS_PARAMS_SVH

// ----------------------------------------
// Register addresses and reset values
// ----------------------------------------
`define CGS_ADDR_GIT 8'h9B
`define CGS_ADDR_GSTA 8'hAA
`define CGS_GSTA_RST 8'h00
`define CGS_GIT_RST 8'h00
`define CGS_RDATA_IDLE 8'h00

// ----------------------------------------
// Protocol figures
// ----------------------------------------
`define CGS_TIMER_MAX 16'hFFFF
`define CGS_TIMER_ZERO 16'h0000
`define CGS_STUFF_LIMIT 3'h5
`define CGS_STUFF_ONE 3'h1
`define CGS_STUFF_ZERO 3'h0
`define CGS_CRC_POLY 15'h4599
`define CGS_CRC_ZERO 15'h0000
`define CGS_PASSIVE_LIMIT 9'h080
`define CGS_BUSOFF_LIMIT 9'h100

`endif

// *** hdl/cgs_pkg.sv ***
// Types shared by the CAN general status and error flag block
// Assumes the constants header sits beside it
package cgs_pkg;
`include "cgs_params.svh"

   // ----------------------------------------
   // Register images
   // ----------------------------------------
   typedef struct packed {
      logic resv7;
      logic overloadSendingFlag;
      logic resv5;
      logic transmitterBusyFlag;
      logic receiverBusyFlag;
      logic enableStateFlag;
      logic busOffState;
      logic errorPassiveState;
   } cgs_status_t;

   typedef struct packed {
      logic globalIrqImage;
      logic resv6;
      logic timerOverrunFlag;
      logic bufferOverrunFlag;
      logic stuffErrorFlag;
      logic crcErrorFlag;
      logic formErrorFlag;
      logic ackErrorFlag;
   } cgs_irq_t;

   // ----------------------------------------
   // Frame engine levels and pulses
   // ----------------------------------------
   typedef struct packed {
      logic txFrame;    // Transmitter drives a frame
      logic ackDrive;   // Transmitter drives an ack field
      logic frameWait;  // A frame waits to be sent
      logic ifs;        // Interframe spacing
      logic rxActive;   // Receiver acquires or monitors
      logic ovlSend;    // Own overload frame on the bus
      logic ovlStart;   // Own overload frame begins
      logic rxMsgEnd;   // Received message completed
   } cgs_frame_t;

   // ----------------------------------------
   // Per-bit receive information
   // ----------------------------------------
   typedef struct packed {
      logic strobe;      // One bus bit sampled
      logic value;       // Sampled level, 0 is dominant
      logic stuffRegion; // Bit lies in the stuffed part
      logic sof;         // Start of frame bit
      logic crcCalc;     // Destuffed bit from SOF to data
      logic crcRecv;     // Destuffed bit of the CRC field
      logic crcCompare;  // CRC field complete
      logic fixedForm;   // Delimiter or end of frame bit
      logic ackSlot;     // Acknowledge slot bit
   } cgs_bit_t;

   typedef enum logic [2:0] {
      CGS_OFF   = 3'h0,
      CGS_WAKE  = 3'h1,
      CGS_START = 3'h2,
      CGS_RUN   = 3'h3,
      CGS_DRAIN = 3'h4
   } cgs_ctl_state_t;

endpackage : cgs_pkg

// *** hdl/cgs_crc15.sv ***
// CRC checker over destuffed received bits
// Assumes the frame engine marks SOF, data and CRC field bits
`timescale 1ns/1ps
`include "cgs_params.svh"
module cgs_crc15 (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic clear,
   input wire logic calcEn,
   input wire logic recvEn,
   input wire logic compare,
   input wire logic bitValue,
   output logic mismatch
);
   import cgs_pkg::*;

   logic [14:0] crc_reg, crc_next;
   logic [14:0] recv_reg, recv_next;
   logic mismatch_next;
   logic feedback;

   // --------------------------------
   // Next CRC and received field
   // --------------------------------
   always_comb begin
      feedback = bitValue ^ crc_reg[14];
      crc_next = crc_reg;
      recv_next = recv_reg;
      if (clear) begin
         crc_next = `CGS_CRC_ZERO;
         recv_next = `CGS_CRC_ZERO;
      end else if (calcEn) begin
         crc_next = {crc_reg[13:0], 1'b0} ^ (feedback ? `CGS_CRC_POLY : `CGS_CRC_ZERO);
      end else if (recvEn) begin
         recv_next = {recv_reg[13:0], bitValue};
      end
      mismatch_next = compare && (recv_reg != crc_reg);
   end

   // Register stage
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         crc_reg <= `CGS_CRC_ZERO;
         recv_reg <= `CGS_CRC_ZERO;
         mismatch <= 1'b0;
      end else begin
         crc_reg <= crc_next;
         recv_reg <= recv_next;
         mismatch <= mismatch_next;
      end
   end

   a_crc_mismatch: assert property (@(posedge sys_clk) disable iff (!rst_n)
      compare && (recv_reg != crc_reg) |=> mismatch) else $error("CRC mismatch not flagged");

endmodule : cgs_crc15

// *** hdl/cgs_fault_conf.sv ***
// Fault confinement states from the error counters
// Assumes counters come from the error counting logic
`timescale 1ns/1ps
`include "cgs_params.svh"
module cgs_fault_conf (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [8:0] txErrCount,
   input wire logic [7:0] rxErrCount,
   output logic busOff,
   output logic errPassive
);
   import cgs_pkg::*;

   logic busOff_next, errPassive_next;

   // Threshold compare
   always_comb begin
      busOff_next = txErrCount >= `CGS_BUSOFF_LIMIT;
      errPassive_next = !busOff_next && ((txErrCount >= `CGS_PASSIVE_LIMIT)
         || ({1'b0, rxErrCount} >= `CGS_PASSIVE_LIMIT));
   end

   // Register stage
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         busOff <= 1'b0;
         errPassive <= 1'b0;
      end else begin
         busOff <= busOff_next;
         errPassive <= errPassive_next;
      end
   end

   a_busoff_state: assert property (@(posedge sys_clk) disable iff (!rst_n)
      txErrCount >= `CGS_BUSOFF_LIMIT |=> busOff && !errPassive) else $error("Bus-off missed");

endmodule : cgs_fault_conf

// *** bench/cgs_bus_node.sv ***
// Far-side CAN node model: places one received bus bit per request
// Assumes requests arrive just after a rising sys_clk edge
`timescale 1ns/1ps
module cgs_bus_node (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic sendReq,
   input wire cgs_pkg::cgs_bit_t sendBit,
   output cgs_pkg::cgs_bit_t busBit
);
   import cgs_pkg::*;
   // One strobe per requested bit; idle level toggles so no stale value lingers
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         busBit <= '0;
      end else if (sendReq) begin
         busBit <= sendBit;
         busBit.strobe <= 1'b1;
      end else begin
         busBit <= '0;
         busBit.value <= ~busBit.value;
      end
   end
endmodule : cgs_bus_node

// *** bench/can_general_status_and_error_flags_bench.sv ***
// Self-checking bench for the CAN general status and interrupt flag block
// Assumes package, design and bus node model are compiled first
`timescale 1ns/1ps
module can_general_status_and_error_flags_bench;
   import cgs_pkg::*;
   // ----------------------------------------
   // Signals and model state
   // ----------------------------------------
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] sfrAddr = 8'h00;
   logic [7:0] sfrWdata = 8'h00;
   logic [7:0] sfrRdata, rd;
   logic sfrWr = 1'b0, sfrRd = 1'b0, timerTick = 1'b0, bufferFull = 1'b0, otherIrq = 1'b0;
   logic controllerEnableCmd = 1'b0, overloadRequestSet = 1'b0, sendReq = 1'b0, mEn = 1'b0;
   logic timerIrqEnable = 1'b0, bufIrqEnable = 1'b1, errIrqEnable = 1'b1;
   logic canIrq, protoRun, overloadRequest, overloadGo;
   logic [8:0] txErrCount = 9'h000;
   logic [7:0] rxErrCount = 8'h00;
   cgs_frame_t frameIn = '0;
   cgs_bit_t bitIn, sendBit = '0, b;
   int errors = 0, samplesChecked = 0, cycles = 0, mFlags = 0, i, seed = 32'h4E3B;
   int tecT[5] = '{127, 128, 0, 255, 256};
   int recT[5] = '{127, 0, 128, 0, 0};
   logic [1:0] errT[5] = '{2'h0, 2'h1, 2'h1, 2'h1, 2'h2};

   // Clock and hang guard
   always #12.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 90000) begin
         errors++;
         test_done();
      end
   end

   cgs_status_flags cgs_status_flags_i (.sys_clk, .rst_n, .sfrAddr, .sfrWr, .sfrRd, .sfrWdata, .sfrRdata,
      .frameIn, .bitIn, .txErrCount, .rxErrCount, .timerTick, .bufferFull, .controllerEnableCmd,
      .overloadRequestSet, .timerIrqEnable, .bufIrqEnable, .errIrqEnable, .otherIrq, .canIrq, .protoRun,
      .overloadRequest, .overloadGo);
   cgs_bus_node cgs_bus_node_i (.sys_clk, .rst_n, .sendReq, .sendBit, .busBit(bitIn));

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task test_done();
      if (errors == 0 && samplesChecked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : test_done

   task step(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : step

   task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      samplesChecked++;
      if (got !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task sfrWrite(input logic [7:0] a, input logic [7:0] d);
      sfrAddr = a;
      sfrWdata = d;
      sfrWr = 1'b1;
      step(1);
      sfrWr = 1'b0;
      step(1);
   endtask : sfrWrite

   task sfrRead(input logic [7:0] a, output logic [7:0] d);
      sfrAddr = a;
      sfrRd = 1'b1;
      step(1);
      d = sfrRdata;
      sfrRd = 1'b0;
      step(1);
   endtask : sfrRead

   // Interrupt register and line against the model flags
   task chkIrq();
      logic g;
      logic [7:0] d;
      g = (mFlags[5] & timerIrqEnable) | (mFlags[4] & bufIrqEnable) | ((|mFlags[3:0]) & errIrqEnable) | otherIrq;
      sfrRead(8'h9B, d);
      chk("irqFlags", {g, 1'b0, mFlags[5:0]}, d & 8'hBF);
      chk("canIrq", {7'h00, g}, {7'h00, canIrq});
   endtask : chkIrq

   task chkSta(input logic [1:0] err);
      logic [7:0] d;
      sfrRead(8'hAA, d);
      chk("status", {1'b0, frameIn.ovlSend, 1'b0, frameIn.txFrame | frameIn.ackDrive | (frameIn.ifs & frameIn.frameWait),
         frameIn.rxActive, mEn, err}, d);
   endtask : chkSta

   task sendBits(input cgs_bit_t v, input int n);
      sendBit = v;
      sendReq = 1'b1;
      step(n);
      sendReq = 1'b0;
      step(3);
   endtask : sendBits

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      step(4);
      rst_n = 1'b1;
      chkSta(2'h0);
      chkIrq();
      sfrWrite(8'hAA, 8'h5F);
      chkSta(2'h0);
      sfrRead(8'h55, rd);
      chk("unmapped", 8'h00, rd);
      // Enable lags the command by the start-up clocks
      controllerEnableCmd = 1'b1;
      step(2);
      chk("protoRun", 8'h00, {7'h00, protoRun});
      step(1);
      chk("protoRun", 8'h01, {7'h00, protoRun});
      mEn = 1'b1;
      // Random frame engine levels
      for (i = 0; i < 24; i++) begin
         frameIn = cgs_frame_t'(8'($random(seed)) & 8'hFC);
         step(2);
         chkSta(2'h0);
      end
      frameIn = '0;
      // Fault confinement thresholds
      for (i = 0; i < 5; i++) begin
         txErrCount = 9'(tecT[i]);
         rxErrCount = 8'(recT[i]);
         step(3);
         chkSta(errT[i]);
      end
      txErrCount = 9'h000;
      step(3);
      // Five equal bits pass, the sixth is a stuff error
      b = '0;
      b.stuffRegion = 1'b1;
      sendBits(b, 5);
      b.value = 1'b1;
      sendBits(b, 1);
      chkIrq();
      sendBits(b, 5);
      mFlags[3] = 1'b1;
      chkIrq();
      sfrWrite(8'h9B, 8'h00);
      mFlags = 0;
      // Fixed-form and acknowledge slot levels
      for (i = 0; i < 4; i++) begin
         b = '0;
         b.fixedForm = (i < 2);
         b.ackSlot = (i >= 2);
         b.value = i[0];
         sendBits(b, 1);
         mFlags = mFlags | ((i == 0) ? 2 : (i == 3) ? 1 : 0);
         chkIrq();
      end
      sfrWrite(8'h9B, 8'hBE);
      mFlags = 2;
      chkIrq();
      // Error interrupts masked: flag stays, global image drops
      errIrqEnable = 1'b0;
      step(1);
      chkIrq();
      errIrqEnable = 1'b1;
      sfrWrite(8'h9B, 8'h00);
      mFlags = 0;
      // Zero data gives a zero CRC; last received bit decides
      for (i = 0; i < 2; i++) begin
         b = '0;
         b.sof = 1'b1;
         b.crcCalc = 1'b1;
         sendBits(b, 1);
         b.sof = 1'b0;
         sendBits(b, 8);
         b = '0;
         b.crcRecv = 1'b1;
         sendBits(b, 14);
         b.value = i[0];
         sendBits(b, 1);
         b = '0;
         b.crcCompare = 1'b1;
         sendBits(b, 1);
         mFlags[2] = i[0];
         chkIrq();
      end
      sfrWrite(8'h9B, 8'h00);
      mFlags = 0;
      // Buffer overrun, masking and the global image
      bufferFull = 1'b1;
      step(2);
      mFlags[4] = 1'b1;
      chkIrq();
      bufIrqEnable = 1'b0;
      step(2);
      chkIrq();
      sfrWrite(8'h9B, 8'h00);
      mFlags = 0;
      chkIrq();
      bufferFull = 1'b0;
      otherIrq = 1'b1;
      step(2);
      chkIrq();
      otherIrq = 1'b0;
      // Timer wrap at the last tick only
      timerTick = 1'b1;
      step(65535);
      timerTick = 1'b0;
      step(2);
      chkIrq();
      timerTick = 1'b1;
      step(1);
      timerTick = 1'b0;
      step(2);
      mFlags[5] = 1'b1;
      chkIrq();
      timerIrqEnable = 1'b1;
      step(2);
      chkIrq();
      sfrWrite(8'h9B, 8'h9F);
      mFlags = 0;
      chkIrq();
      // Overload request life cycle
      overloadRequestSet = 1'b1;
      step(1);
      overloadRequestSet = 1'b0;
      chk("overload", 8'h02, {6'h00, overloadRequest, overloadGo});
      frameIn.rxMsgEnd = 1'b1;
      step(1);
      frameIn.rxMsgEnd = 1'b0;
      chk("overload", 8'h03, {6'h00, overloadRequest, overloadGo});
      frameIn.ovlStart = 1'b1;
      step(1);
      frameIn.ovlStart = 1'b0;
      chk("overload", 8'h00, {6'h00, overloadRequest, overloadGo});
      // Disable waits for the frame in progress
      frameIn.txFrame = 1'b1;
      controllerEnableCmd = 1'b0;
      step(4);
      chk("protoRun", 8'h01, {7'h00, protoRun});
      frameIn = '0;
      step(4);
      chk("protoRun", 8'h00, {7'h00, protoRun});
      test_done();
   end
endmodule : can_general_status_and_error_flags_bench
